// File: hdl/rps_pkg.sv
package rps_pkg;
    localparam int CLK_HZ = 25000000;
    // longest enable-to-power-good delay, in microseconds
    localparam int PG_MAX_US = 6000;
    localparam int PG_MAX_CYC = (PG_MAX_US / 1000) * (CLK_HZ / 1000);
    // settle time of the core supply before power good, in microseconds
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1000000);
    localparam int CNT_W = 24;

    typedef enum logic [1:0] {
        RPS_OFF = 2'b00,
        RPS_RAMP = 2'b01,
        RPS_SETTLE = 2'b11,
        RPS_GOOD = 2'b10
    } rps_state_t;

    // sampled analogue monitors, after synchronising
    typedef struct packed {
        logic enable;
        logic core_in_tol;
        logic dc_min_ok;
    } rps_mon_t;
endpackage

// File: hdl/rps_sync.sv
`timescale 1ns/1ns
`default_nettype none
module rps_sync #(
    parameter int W = 3
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // a change counts only once stages two and three agree
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            Q <= '0;
        end else if (CE) begin
            s1_reg <= D;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    Q[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/rps_top.sv
// Notes on behaviour
// - regulator runs while regulator_enable is high, off while low.
// - power good rises once core supply is within its tolerance band.
// - power good waits for stable core and main DC input at minimum.
// - power good is due within 6.0 ms of enable rising; a later start only sets STARTUP_LATE.
`timescale 1ns/1ns
`default_nettype none
module rps_top
    import rps_pkg::*;
#(
    parameter int PG_MAX = PG_MAX_CYC,
    parameter int SETTLE = SETTLE_CYC
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic REGULATOR_ENABLE,
    input wire logic CORE_IN_TOL,
    input wire logic MAIN_DC_OK,
    output logic REGULATOR_ON,
    output logic REGULATOR_POWER_GOOD,
    output logic REGULATOR_POWER_GOOD_OE,
    output logic STARTUP_LATE
);
    rps_mon_t mon;
    rps_state_t state_reg;
    rps_state_t state_next;
    logic [CNT_W-1:0] wait_reg;
    logic [CNT_W-1:0] settle_reg;

    // core in band and main input at minimum; both gate power good
    function automatic logic supplies_ok(input rps_mon_t m);
        return m.core_in_tol && m.dc_min_ok;
    endfunction

    rps_sync #(.W(3)) u_sync (
        .MCLK(MCLK),
        .RESET(RESET),
        .CE(CE),
        .D({REGULATOR_ENABLE, CORE_IN_TOL, MAIN_DC_OK}),
        .Q(mon)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RPS_OFF: if (mon.enable) state_next = RPS_RAMP;
            RPS_RAMP: begin
                if (!mon.enable) state_next = RPS_OFF;
                else if (supplies_ok(mon)) state_next = RPS_SETTLE;
            end
            RPS_SETTLE: begin
                if (!mon.enable) state_next = RPS_OFF;
                else if (!supplies_ok(mon)) state_next = RPS_RAMP;
                else if (settle_reg >= CNT_W'(SETTLE - 1)) state_next = RPS_GOOD;
            end
            RPS_GOOD: begin
                if (!mon.enable) state_next = RPS_OFF;
                else if (!supplies_ok(mon)) state_next = RPS_RAMP;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) state_reg <= RPS_OFF;
        else if (CE) state_reg <= state_next;
    end

    // settle window: short, so power good still lands inside the 6 ms budget
    always_ff @(posedge MCLK) begin
        if (RESET) settle_reg <= '0;
        else if (CE) begin
            if (state_reg == RPS_SETTLE) settle_reg <= settle_reg + CNT_W'(1);
            else settle_reg <= '0;
        end
    end

    // counts from enable rise; flags a start that blows the budget
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            wait_reg <= '0;
            STARTUP_LATE <= 1'b0;
        end else if (CE) begin
            if (!mon.enable) begin
                wait_reg <= '0;
                STARTUP_LATE <= 1'b0;
            end else if (state_reg != RPS_GOOD) begin
                if (wait_reg < CNT_W'(PG_MAX)) wait_reg <= wait_reg + CNT_W'(1);
                else STARTUP_LATE <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) REGULATOR_ON <= 1'b0;
        else if (CE) REGULATOR_ON <= mon.enable;
    end

    always_ff @(posedge MCLK) begin
        if (RESET) REGULATOR_POWER_GOOD <= 1'b0;
        else if (CE) REGULATOR_POWER_GOOD <= (state_next == RPS_GOOD);
    end

    // push-pull: board must not pull this line up
    assign REGULATOR_POWER_GOOD_OE = 1'b1;

    // regulator switching follows the filtered enable
    pg_needs_on_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        REGULATOR_POWER_GOOD |-> REGULATOR_ON)
        else $error("power good without regulator on");
    on_follows_en_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && $changed(mon.enable) |=> REGULATOR_ON == $past(mon.enable))
        else $error("regulator on does not follow enable");
    on_low_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && !mon.enable |=> !REGULATOR_ON)
        else $error("regulator on with enable low");
    on_high_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && mon.enable |=> REGULATOR_ON)
        else $error("regulator off with enable high");
    pg_drop_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && !mon.enable |=> !REGULATOR_POWER_GOOD)
        else $error("power good stays with enable low");
    off_state_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && !mon.enable |=> state_reg == RPS_OFF)
        else $error("state not off with enable low");

    // power good only after a full settle inside the band
    pg_settle_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        $rose(REGULATOR_POWER_GOOD) |-> $past(state_reg) == RPS_SETTLE)
        else $error("power good skipped settle");
    tol_loss_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && !mon.core_in_tol |=> !REGULATOR_POWER_GOOD)
        else $error("power good held outside tolerance");
    settle_done_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        $rose(REGULATOR_POWER_GOOD) |-> $past(settle_reg) == CNT_W'(SETTLE - 1))
        else $error("power good before settle count");
    pg_hold_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && REGULATOR_POWER_GOOD && mon.enable && supplies_ok(mon) |=> REGULATOR_POWER_GOOD)
        else $error("power good dropped with supplies ok");
    good_exit_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && state_reg == RPS_GOOD && !supplies_ok(mon) |=> state_reg != RPS_GOOD)
        else $error("good state kept with supplies lost");
    settle_clear_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && state_reg != RPS_SETTLE |=> settle_reg == '0)
        else $error("settle count not cleared");

    // main input minimum gates the climb from ramp to power good
    pg_needs_dc_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        $rose(REGULATOR_POWER_GOOD) |-> $past(mon.dc_min_ok) && $past(mon.core_in_tol))
        else $error("power good rose without supplies ok");
    dc_loss_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && !mon.dc_min_ok |=> !REGULATOR_POWER_GOOD)
        else $error("power good held with main input low");
    ramp_wait_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && state_reg == RPS_RAMP && !supplies_ok(mon) |=> !REGULATOR_POWER_GOOD)
        else $error("power good during ramp");
    settle_entry_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && state_reg == RPS_RAMP && mon.enable && supplies_ok(mon) |=> state_reg == RPS_SETTLE)
        else $error("settle not entered");

    // late flag is a diagnostic only; it never holds power good back
    late_flag_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        $rose(STARTUP_LATE) |-> wait_reg == CNT_W'(PG_MAX) && !REGULATOR_POWER_GOOD)
        else $error("late flag at wrong time");
    late_needs_on_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        STARTUP_LATE |-> REGULATOR_ON)
        else $error("late flag with regulator off");
    wait_bound_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        wait_reg <= CNT_W'(PG_MAX))
        else $error("startup counter past budget");
    late_set_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && mon.enable && state_reg != RPS_GOOD && wait_reg == CNT_W'(PG_MAX) |=> STARTUP_LATE)
        else $error("late flag missing");
    late_clear_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        CE && !mon.enable |=> !STARTUP_LATE)
        else $error("late flag kept with enable low");

    oe_high_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        REGULATOR_POWER_GOOD_OE)
        else $error("power good not driven");

    // a low enable input must freeze every output
    ce_freeze_a: assert property (
        @(posedge MCLK) disable iff (RESET)
        !CE |=> $stable(REGULATOR_ON) && $stable(REGULATOR_POWER_GOOD) && $stable(STARTUP_LATE))
        else $error("outputs moved while frozen");

    start_c: cover property (@(posedge MCLK) $rose(REGULATOR_POWER_GOOD));
    late_c: cover property (@(posedge MCLK) $rose(STARTUP_LATE));
    off_c: cover property (@(posedge MCLK) $fell(REGULATOR_ON));
    lost_c: cover property (@(posedge MCLK) $fell(REGULATOR_POWER_GOOD) && REGULATOR_ON);
    freeze_c: cover property (@(posedge MCLK) !CE && REGULATOR_ON);
endmodule
`default_nettype wire

// File: bench/rps_board_model.sv
`timescale 1ns/1ns
`default_nettype none
module rps_board_model #(
    parameter int MIN_LOW = 8,
    parameter int PG_TIMEOUT = 2000
) (
    input wire logic MCLK,
    input wire logic REGULATOR_ON,
    input wire logic REGULATOR_POWER_GOOD,
    input wire logic WANT_ON,
    input wire logic DC_UP,
    input wire logic CORE_FAULT,
    input wire logic [2:0] RAMP,
    output logic REGULATOR_ENABLE,
    output logic CORE_IN_TOL,
    output logic MAIN_DC_OK,
    output logic SOUTH_BRIDGE_POWER_OK,
    output logic PG_FAULT
);
    int low_cnt = 0;
    int ramp_cnt = 0;
    int pg_wait = 0;
    logic pg_seen = 1'B0;
    // speed select strapped high, so it stands high at every enable rise
    logic speed_level_select = 1'B1;
    wire logic suspend_b_control = WANT_ON;
    wire logic switched_3v3_rail = DC_UP;
    wire logic rise_ok = DC_UP && speed_level_select && low_cnt >= MIN_LOW;
    initial REGULATOR_ENABLE = 1'B0;
    initial CORE_IN_TOL = 1'B0;
    initial SOUTH_BRIDGE_POWER_OK = 1'B0;
    initial PG_FAULT = 1'B0;
    assign MAIN_DC_OK = DC_UP;
    // rails only gate the rising edge; a sagging rail later leaves enable up
    always @(posedge MCLK) begin
        if (REGULATOR_ENABLE && pg_wait >= PG_TIMEOUT) begin
            REGULATOR_ENABLE <= 1'B0;
            PG_FAULT <= 1'B1;
        end else begin
            REGULATOR_ENABLE <= suspend_b_control && (REGULATOR_ENABLE || rise_ok);
        end
        pg_wait <= (REGULATOR_ENABLE && !REGULATOR_POWER_GOOD) ? pg_wait + 1 : 0;
        low_cnt <= REGULATOR_ENABLE ? 0 : low_cnt + 1;
        ramp_cnt <= REGULATOR_ON ? ramp_cnt + 1 : 0;
        CORE_IN_TOL <= REGULATOR_ON && !CORE_FAULT && ramp_cnt >= RAMP;
        pg_seen <= REGULATOR_POWER_GOOD;
        SOUTH_BRIDGE_POWER_OK <= pg_seen && REGULATOR_POWER_GOOD && switched_3v3_rail;
    end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int PGM = 40;
    logic MCLK = 1'B0;
    logic RESET = 1'B1;
    logic CE = 1'B1;
    logic want = 1'B0, dc = 1'B0, flt = 1'B0, en, core, dok, on, pg, oe, late;
    logic [2:0] ramp = 3'H0;
    logic [15:0] lfsr = 16'HD01E;
    logic xen, pexp, sbok, pfault;
    int fail_count = 0, n_checks = 0, cyc = 0, n;
    rps_board_model bm (.MCLK(MCLK), .REGULATOR_ON(on), .WANT_ON(want), .DC_UP(dc),
        .CORE_FAULT(flt), .RAMP(ramp), .REGULATOR_ENABLE(en), .CORE_IN_TOL(core),
        .MAIN_DC_OK(dok), .REGULATOR_POWER_GOOD(pg), .SOUTH_BRIDGE_POWER_OK(sbok),
        .PG_FAULT(pfault));
    rps_top #(.PG_MAX(PGM), .SETTLE(4)) uut (.MCLK(MCLK), .RESET(RESET), .CE(CE),
        .REGULATOR_ENABLE(en), .CORE_IN_TOL(core), .MAIN_DC_OK(dok), .REGULATOR_ON(on),
        .REGULATOR_POWER_GOOD(pg), .REGULATOR_POWER_GOOD_OE(oe), .STARTUP_LATE(late));
    initial begin
        forever #20 MCLK = ~MCLK;
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // wait c cycles, compare oe, on, pg and late against exp, then step one more cycle
    task automatic hold(input int c, input logic [3:0] exp);
        repeat (c) @(posedge MCLK);
        #1 check({oe, on, pg, late}, exp);
        @(posedge MCLK);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge MCLK);
        RESET <= 1'B0;
        hold(1, 4'H8);
        want <= 1'B1;
        dc <= 1'B1;
        ramp <= 3'H7;
        n = 0;
        while (pg !== 1'B1 && n < 200) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        check({3'H0, n <= PGM}, 4'H1);
        hold(2, 4'HE);
        dc <= 1'B0;
        hold(20, 4'HC);
        dc <= 1'B1;
        hold(30, 4'HF);
        flt <= 1'B1;
        hold(20, 4'HD);
        want <= 1'B0;
        hold(20, 4'H8);
        want <= 1'B1;
        hold(PGM + 40, 4'HD);
        CE <= 1'B0;
        want <= 1'B0;
        flt <= 1'B0;
        hold(20, 4'HD);
        CE <= 1'B1;
        hold(60, 4'H8);
        xen = 1'B0;
        for (int i = 0; i < 50; i++) begin
            lfsr = step(lfsr);
            want <= lfsr[0] | lfsr[1];
            dc <= lfsr[2] | lfsr[3];
            flt <= lfsr[4] & lfsr[5];
            ramp <= lfsr[8:6];
            xen = (lfsr[0] | lfsr[1]) & (xen | lfsr[2] | lfsr[3]);
            pexp = xen & (lfsr[2] | lfsr[3]) & ~(lfsr[4] & lfsr[5]);
            repeat (60) @(posedge MCLK);
            #1 check({sbok, oe, on, pg}, {pexp, 1'B1, xen, pexp});
            @(posedge MCLK);
        end
        check({3'H0, pfault}, 4'H0);
        summarize();
    end
endmodule
`default_nettype wire
